// ==== rtl/release_delay_timer.v ====
// release delay timer with power-up modes
// assumes start, stop and reset contacts are debounced and synchronous to CLOCK;
// power presence is RESETN (power loss asserts it)
// Functional notes
// RULE1: release mode: start turns output on immediately
// RULE2: release mode: start release begins timing
// RULE3: release mode: output off after set time
// RULE4: start during interval clears and restarts it
// RULE5: stop freezes elapsed count, keeps it
// RULE6: stop release resumes from retained count
// RULE7: power delay: output on after set time
// RULE8: power loss resets all state and output
// RULE9: mode selects among five power-up behaviours
// RULE10: reset input clears interval, output off
// RULE11: count clock ticks against programmable terminal count
`timescale 1ns/1ps
`include "rdt_consts.vh"
module release_delay_timer #(
    parameter COUNT_W = `COUNT_W
) (
    // clock and power-on reset
    input wire CLOCK,
    input wire RESETN,
    // configuration
    input wire [`MODE_W-1:0] MODE,
    input wire [COUNT_W-1:0] SET_TIME,
    // contact inputs
    input wire START,
    input wire STOP,
    input wire RESET_IN,
    // output contact and timing flag
    output reg TIMED_OUT,
    output wire TIMING
);
    // one-hot state codes
    localparam [3:0] IDLE = `ST_IDLE;
    localparam [3:0] HOLD = `ST_HOLD;
    localparam [3:0] RUN = `ST_TIMING;
    localparam [3:0] DONE = `ST_DONE;
    // count constants sized to the parameter, so no width is padded or cut
    localparam [COUNT_W-1:0] COUNT_CLEAR = {COUNT_W{1'b0}};
    localparam [COUNT_W-1:0] COUNT_STEP = {{(COUNT_W-1){1'b0}}, 1'b1};

    // sequencer and interval counter
    reg [3:0] state;
    reg [3:0] next_state;
    reg [COUNT_W-1:0] count;
    reg [COUNT_W-1:0] next_count;
    reg next_out;
    reg running;
    wire next_running;
    // mode decode
    wire release_delay_mode;
    wire power_mode;
    wire power_delay_mode;
    wire power_flicker_mode;
    wire on_flicker_mode;
    wire one_shot_mode;
    wire one_cycle_mode;
    wire toggle_mode;
    wire first_level;
    // contact qualification and interval bookkeeping
    wire start_seen;
    wire stop_seen;
    wire clear_seen;
    wire in_run;
    wire [COUNT_W-1:0] count_plus;
    wire expire;
    wire frozen;
    wire advance;
    wire lapse;

    assign release_delay_mode = (MODE == `MODE_RELEASE_DELAY);
    // codes beyond the five power behaviours still count as power modes
    assign power_mode = !release_delay_mode;
    assign power_delay_mode = (MODE == `MODE_POWER_DELAY);
    assign power_flicker_mode = (MODE == `MODE_POWER_FLICKER);
    assign on_flicker_mode = (MODE == `MODE_POWER_ON_FLICKER);
    assign one_shot_mode = (MODE == `MODE_POWER_ONE_SHOT);
    assign one_cycle_mode = (MODE == `MODE_POWER_ONE_CYCLE);
    assign toggle_mode = power_flicker_mode || on_flicker_mode || one_cycle_mode;
    // on-first flicker and one-shot open the interval with the contact closed
    assign first_level = on_flicker_mode || one_shot_mode; // RULE9

    // power modes time from power-on and ignore the start contact
    assign start_seen = release_delay_mode && START;
    assign stop_seen = STOP;
    assign clear_seen = RESET_IN;
    assign in_run = (state == RUN);

    // a set time of zero still needs one tick, so compare after increment
    assign count_plus = count + COUNT_STEP;
    assign expire = (count_plus >= SET_TIME); // RULE11
    // stop only pauses a running interval; elsewhere it has no effect
    assign frozen = in_run && !start_seen && stop_seen;
    assign advance = in_run && !start_seen && !stop_seen && !expire;
    assign lapse = in_run && !start_seen && !stop_seen && expire;

    assign next_running = (next_state == RUN);
    assign TIMING = running;

    // state sequencing
    always @* begin
        next_state = state;
        case (state)
            IDLE: begin
                if (power_mode) begin
                    next_state = RUN; // RULE9
                end else if (start_seen) begin
                    next_state = HOLD; // RULE1
                end
            end
            HOLD: begin
                // the interval opens only once the contact lets go
                if (!START) begin
                    next_state = RUN; // RULE2
                end
            end
            RUN: begin
                if (start_seen) begin
                    next_state = HOLD; // RULE4
                end else if (lapse) begin
                    case (MODE)
                        `MODE_RELEASE_DELAY: begin
                            next_state = IDLE; // RULE3
                        end
                        `MODE_POWER_DELAY: begin
                            next_state = DONE; // RULE7
                        end
                        `MODE_POWER_FLICKER: begin
                            next_state = RUN;
                        end
                        `MODE_POWER_ON_FLICKER: begin
                            next_state = RUN;
                        end
                        `MODE_POWER_ONE_SHOT: begin
                            next_state = DONE;
                        end
                        `MODE_POWER_ONE_CYCLE: begin
                            // one full off-on cycle, then park
                            if (TIMED_OUT) begin
                                next_state = DONE;
                            end
                        end
                        default: begin
                            next_state = IDLE;
                        end
                    endcase
                end
            end
            DONE: begin
                // leaving power modes drops back to idle so release mode starts clean
                if (!power_mode) begin
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
        if (clear_seen) begin
            // release mode returns to idle; power modes wait for the next power-on
            if (power_mode) begin
                next_state = DONE; // RULE10
            end else begin
                next_state = IDLE; // RULE10
            end
        end
    end

    // elapsed count
    always @* begin
        next_count = count;
        if (!in_run) begin
            next_count = COUNT_CLEAR;
        end else if (start_seen) begin
            next_count = COUNT_CLEAR; // RULE4
        end else if (frozen) begin
            next_count = count; // RULE5
        end else if (advance) begin
            next_count = count_plus; // RULE6
        end else begin
            // each lapse starts the next period from zero
            next_count = COUNT_CLEAR;
        end
        if (clear_seen) begin
            next_count = COUNT_CLEAR; // RULE10
        end
    end

    // output contact
    always @* begin
        next_out = TIMED_OUT;
        case (state)
            IDLE: begin
                if (power_mode) begin
                    next_out = first_level; // RULE9
                end else if (start_seen) begin
                    next_out = 1'b1; // RULE1
                end
            end
            HOLD: begin
                next_out = TIMED_OUT;
            end
            RUN: begin
                if (lapse) begin
                    if (release_delay_mode) begin
                        next_out = 1'b0; // RULE3
                    end else if (power_delay_mode) begin
                        next_out = 1'b1; // RULE7
                    end else if (toggle_mode) begin
                        next_out = !TIMED_OUT; // RULE9
                    end else if (one_shot_mode) begin
                        next_out = 1'b0;
                    end
                end
            end
            DONE: begin
                if (!power_mode) begin
                    next_out = 1'b0;
                end
            end
            default: begin
                next_out = 1'b0;
            end
        endcase
        if (clear_seen) begin
            next_out = 1'b0; // RULE10
        end
    end

    // power loss returns sequencer and count to rest
    always @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state <= IDLE; // RULE8
            count <= COUNT_CLEAR;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // output and timing flag are registered so neither glitches on decode
    always @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            TIMED_OUT <= 1'b0; // RULE8
            running <= 1'b0;
        end else begin
            TIMED_OUT <= next_out;
            running <= next_running;
        end
    end
endmodule

// ==== pkg/rdt_consts.vh ====
// constants for the release delay timer
// assumes inclusion by the design file only
`ifndef RDT_CONSTS_VH
`define RDT_CONSTS_VH
`define MODE_W 3
`define MODE_RELEASE_DELAY 3'h0
`define MODE_POWER_DELAY 3'h1
`define MODE_POWER_FLICKER 3'h2
`define MODE_POWER_ON_FLICKER 3'h3
`define MODE_POWER_ONE_SHOT 3'h4
`define MODE_POWER_ONE_CYCLE 3'h5
`define COUNT_W 32
`define COUNT_ZERO 32'h0000_0000
`define COUNT_ONE 32'h0000_0001
`define ST_IDLE 4'h1
`define ST_HOLD 4'h2
`define ST_TIMING 4'h4
`define ST_DONE 4'h8
`endif

// ==== tb/rdt_monitor.sv ====
// port checker for the release delay timer
// assumes contacts synchronous to CLOCK and stable SET_TIME per interval
`timescale 1ns/1ps
module rdt_monitor #(parameter COUNT_W = 32) (
    input wire CLOCK, RESETN, START, STOP, RESET_IN, TIMED_OUT, TIMING,
    input wire [2:0] MODE,
    input wire [COUNT_W-1:0] SET_TIME);
    wire rel = MODE == 3'h0;
    wire run = rel && TIMING && !START && !RESET_IN;
    reg [31:0] cnt, pw;
    always @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cnt <= 0;
            pw <= 0;
        end else begin
            pw <= pw + 1;
            cnt <= run ? cnt + !STOP : 0;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    on_now_a: assert property (rel && START && !RESET_IN |=> TIMED_OUT)
        else $error("output not on");
    go_a: assert property (rel && TIMED_OUT && !TIMING && !START && !RESET_IN |=> TIMING)
        else $error("timing not begun");
    end_a: assert property (run && !STOP && cnt + 1 >= SET_TIME |=> !TIMED_OUT)
        else $error("output not off");
    keep_a: assert property (run && cnt + 1 < SET_TIME |=> TIMED_OUT && TIMING)
        else $error("interval lost");
    restart_a: assert property (rel && TIMING && START && !RESET_IN |=> TIMED_OUT && !TIMING)
        else $error("no restart");
    clear_a: assert property (rel && RESET_IN |=> !TIMED_OUT && !TIMING)
        else $error("reset ignored");
    power_on_a: assert property ($rose(TIMED_OUT) && MODE == 3'h1 |-> pw == SET_TIME + 1)
        else $error("power delay wrong");
    power_reset_a: assert property ($rose(RESETN) |-> !TIMED_OUT && !TIMING)
        else $error("state kept");
    cover property (run && STOP);
    cover property (rel && TIMING && START);
    cover property (MODE == 3'h1 && $rose(TIMED_OUT));
    cover property (MODE == 3'h2 && $fell(TIMED_OUT));
endmodule
bind release_delay_timer rdt_monitor #(.COUNT_W(COUNT_W)) mon (.CLOCK(CLOCK), .RESETN(RESETN),
    .START(START), .STOP(STOP), .RESET_IN(RESET_IN), .TIMED_OUT(TIMED_OUT), .TIMING(TIMING),
    .MODE(MODE), .SET_TIME(SET_TIME));

// ==== tb/contact_bank.sv ====
// contact closures on start, stop and reset
// assumes clean levels; bounce belongs to the front end
`timescale 1ns/1ps
module contact_bank (
    input wire [2:0] want,
    output wire START, STOP, RESET_IN);
    assign {START, STOP, RESET_IN} = want;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    reg c = 0, rn = 0;
    reg [2:0] mode = 0, want = 0;
    reg [31:0] t = 4, seed = 32'h5135_1581;
    wire s, p, r, o, tm;
    integer mismatches = 0, total_checks = 0, i, q;
    release_delay_timer dut (.CLOCK(c), .RESETN(rn), .MODE(mode), .SET_TIME(t), .START(s),
        .STOP(p), .RESET_IN(r), .TIMED_OUT(o), .TIMING(tm));
    contact_bank bank (.want(want), .START(s), .STOP(p), .RESET_IN(r));
    initial forever #2.5 c = ~c;
    function exp_pw(input [2:0] m, input [31:0] k);
        reg [31:0] h;
        begin
            h = (k - 1) / 8;
            exp_pw = m == 1 ? h >= 1 : m == 2 ? h[0] : m == 3 ? !h[0] :
                m == 4 ? h == 0 : h == 1;
        end
    endfunction
    function [31:0] xorshift(input [31:0] v);
        reg [31:0] x;
        begin
            x = v ^ (v << 13);
            x = x ^ (x >> 17);
            xorshift = x ^ (x << 5);
        end
    endfunction
    task chk(input [31:0] what, input seen, input exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("FAIL %0s expected %b seen %b", what, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge c);
            #1;
        end
    endtask
    task power(input [2:0] m);
        begin
            rn = 0;
            mode = m;
            tick(6);
            rn = 1;
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #50000 mismatches = mismatches + 1;
        conclude;
    end
    initial begin
        power(0);
        for (i = 0; i < 24; i = i + 1) begin
            seed = xorshift(seed);
            t = seed[2:0] + 4;
            want = 4;
            tick(1);
            chk("on", o, 1);
            want = 0;
            tick(1);
            chk("run", tm, 1);
            if (seed[3]) begin
                want = 2;
                tick(3);
                chk("held", o, 1);
                want = 0;
            end
            if (seed[4]) begin
                tick(1);
                want = 4;
                tick(1);
                chk("rst", tm, 0);
                want = 0;
                tick(1);
            end
            tick(t - 2);
            chk("late", o, 1);
            want = {2'b00, seed[5]};
            tick(1);
            chk("clr", o, !seed[5]);
            want = 0;
            tick(1);
            chk("off", o, 0);
        end
        t = 8;
        for (i = 1; i < 6; i = i + 1) begin
            power(i[2:0]);
            chk("pwr", o, 0);
            chk("pwr", tm, 0);
            tick(5);
            q = 5;
            repeat (4) begin
                chk("mode", o, exp_pw(i[2:0], q));
                q = q + 8;
                tick(8);
            end
        end
        conclude;
    end
endmodule
